// ==== hdl/wdt_cfg.svh ====
// Register offsets, field positions, reset values and event bits of the watchdog
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define WDT_OFS_CONTROL 8'h00
`define WDT_OFS_RESTART 8'h04
`define WDT_OFS_LIMIT 8'h08
`define WDT_OFS_COUNT 8'h0c
`define WDT_OFS_PULSE_LEN 8'h10
`define WDT_OFS_IRQ_STATUS 8'h14
`define WDT_OFS_IRQ_MASK 8'h18

// ****************************************
// Field positions
// ****************************************
`define WDT_CTL_RUN_BIT 0
`define WDT_CTL_PEND_BIT 2
`define WDT_CTL_RST_EN_BIT 4
`define WDT_CTL_IRQ_EN_BIT 5
`define COUNT_RESTART_STROBE_BIT 0
`define WDT_PULSE_MSB 7

// ****************************************
// Reset values and event bits
// ****************************************
`define WDT_LIMIT_RST 32'h0000_ffff
`define WDT_PULSE_RST 8'hff
`define WDT_EVT_FIRST 0
`define WDT_EVT_SECOND 1
`define WDT_EVT_RESET 2
`define WDT_EVT_WIDTH 3

`endif

// ==== hdl/wdt_pkg.sv ====
// Types shared by the watchdog modules
package wdt_pkg;

  // Timeout sequencing phase
  typedef enum logic [1:0] {
    WDT_IDLE = 2'b00,
    WDT_FIRST = 2'b01,
    WDT_SECOND = 2'b10,
    WDT_PULSE = 2'b11
  } wdt_phase_t;

  // One decoded bus access, valid for a single cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } wdt_acc_t;

  // Signals towards the reset and interrupt side
  typedef struct packed {
    logic irq_to_core;
    logic irq_to_intc;
    logic reset_n;
    logic timeout_seen;
  } wdt_sys_t;

endpackage

// ==== hdl/wdt_apb_slave.sv ====
// APB slave front end of the watchdog: single-cycle access decode
`timescale 1ns/1ns
`include "wdt_cfg.svh"

module wdt_apb_slave (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  // Decoded access
  output wdt_pkg::wdt_acc_t acc
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ready;
    logic err;
  } wdt_slv_t;

  wdt_slv_t st_ff;
  wdt_slv_t nxt_st;
  logic access;
  logic mapped;

  // Access is decoded in the first access cycle; ready is a flop, so the transfer completes one cycle later
  assign access = psel & penable & ~st_ff.ready;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `WDT_OFS_IRQ_MASK);

  // Next-state and access decode
  always_comb begin
    nxt_st.ready = access;
    nxt_st.err = access & ~mapped;
    acc.wr = access & pwrite & mapped;
    acc.rd = access & ~pwrite & mapped;
    acc.addr = paddr;
    acc.wdata = pwdata;
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;

endmodule

// ==== hdl/wdt_top.sv ====
// Two-stage watchdog timer with APB registers
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "wdt_cfg.svh"

// Notes on behaviour
// [R01] Counter runs only while run enable set
// [R02] First timeout raises interrupt when enabled
// [R03] Second timeout asserts reset when enabled
// [R04] Pending bit set by timeout, write-one clears
// [R05] Restart register bit zero restarts count
// [R06] Timeout after limit register cycles
// [R07] Live count readable, resets to limit
// [R08] Reset low for programmed pulse cycles
// [R09] Software leaves limit, pulse alone while running
// [R10] All registers return to reset values
// [R11] Timeout-seen flag to clock manager
// [R12] Interrupt routed to core and controller
// [R13] Load, decrement, timeout at zero, reload
// [R14] Reserved bits read zero, writes ignored
module wdt_top #(
  parameter int CNT_W = 32,
  parameter int PULSE_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System side
  output logic wdt_irq,
  output logic irq_to_core,
  output logic irq_to_intc,
  output logic wdt_reset_n,
  output logic timeout_seen_flag
);

  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (CNT_W != 32 || PULSE_W != 8 || `WDT_PULSE_MSB + 1 != PULSE_W) begin
      $error("wdt_top: register widths must be 32 and 8");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic watchdog_run_enable;
    logic timeout_irq_enable;
    logic timeout_reset_enable;
    logic timeout_irq_pending;
    logic [CNT_W-1:0] timeout_limit;
    logic [CNT_W-1:0] live_count;
    logic [PULSE_W-1:0] reset_pulse_cycles;
    logic [PULSE_W-1:0] pulse_left;
    wdt_pkg::wdt_phase_t phase;
    logic [`WDT_EVT_WIDTH-1:0] evt_status;
    logic [`WDT_EVT_WIDTH-1:0] evt_mask;
    logic [31:0] rdata;
    wdt_pkg::wdt_sys_t sys;
    logic irq;
  } wdt_state_t;

  wdt_state_t st_ff;
  wdt_state_t nxt_st;
  wdt_pkg::wdt_acc_t acc;
  logic [`WDT_EVT_WIDTH-1:0] evt;
  logic expire;
  logic restart;
  logic start;

  // ****************************************
  // Bus front end
  // ****************************************
  wdt_apb_slave u_slave (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .acc(acc)
  );

  // Restart strobe is write-only and stores nothing
  assign restart = acc.wr && acc.addr == `WDT_OFS_RESTART &&
                   acc.wdata[`COUNT_RESTART_STROBE_BIT]; // see [R05]
  // Rising run enable loads the limit
  assign start = acc.wr && acc.addr == `WDT_OFS_CONTROL &&
                 acc.wdata[`WDT_CTL_RUN_BIT] && !st_ff.watchdog_run_enable;
  // Expiry when running count reaches zero
  assign expire = st_ff.watchdog_run_enable && st_ff.live_count == '0 &&
                  !restart && !start; // see [R13]

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    evt = '0;

    // Control register write; pending is write-one-to-clear
    if (acc.wr && acc.addr == `WDT_OFS_CONTROL) begin
      nxt_st.watchdog_run_enable = acc.wdata[`WDT_CTL_RUN_BIT]; // see [R01]
      nxt_st.timeout_irq_enable = acc.wdata[`WDT_CTL_IRQ_EN_BIT];
      nxt_st.timeout_reset_enable = acc.wdata[`WDT_CTL_RST_EN_BIT];
      if (acc.wdata[`WDT_CTL_PEND_BIT]) begin
        nxt_st.timeout_irq_pending = 1'b0; // see [R04]
      end
    end
    // Limit and pulse length; writes while running are honoured but unsafe
    if (acc.wr && acc.addr == `WDT_OFS_LIMIT) begin
      nxt_st.timeout_limit = acc.wdata[CNT_W-1:0]; // see [R06] see [R09]
    end
    if (acc.wr && acc.addr == `WDT_OFS_PULSE_LEN) begin
      nxt_st.reset_pulse_cycles = acc.wdata[`WDT_PULSE_MSB:0]; // see [R08] see [R14]
    end
    if (acc.wr && acc.addr == `WDT_OFS_IRQ_MASK) begin
      nxt_st.evt_mask = acc.wdata[`WDT_EVT_WIDTH-1:0];
    end

    // Counter: load on start or restart, hold at limit when disabled
    if (start || restart) begin
      nxt_st.live_count = st_ff.timeout_limit; // see [R13]
      if (restart) begin
        nxt_st.phase = wdt_pkg::WDT_IDLE;
      end
    end else if (!st_ff.watchdog_run_enable) begin
      nxt_st.live_count = st_ff.timeout_limit; // see [R07]
      nxt_st.phase = wdt_pkg::WDT_IDLE;
    end else if (expire) begin
      nxt_st.live_count = st_ff.timeout_limit; // see [R13]
    end else begin
      nxt_st.live_count = st_ff.live_count - 1'b1; // see [R06]
    end

    // Timeout sequencing
    if (expire) begin
      nxt_st.sys.timeout_seen = 1'b1; // see [R11]
      unique case (st_ff.phase)
        wdt_pkg::WDT_IDLE: begin
          nxt_st.phase = wdt_pkg::WDT_FIRST;
          evt[`WDT_EVT_FIRST] = 1'b1;
          if (st_ff.timeout_irq_enable) begin
            nxt_st.timeout_irq_pending = 1'b1; // see [R02] see [R04]
          end
        end
        wdt_pkg::WDT_FIRST: begin
          evt[`WDT_EVT_SECOND] = 1'b1;
          nxt_st.phase = wdt_pkg::WDT_SECOND;
          if (st_ff.timeout_reset_enable) begin
            nxt_st.phase = wdt_pkg::WDT_PULSE; // see [R03]
            nxt_st.pulse_left = st_ff.reset_pulse_cycles;
            evt[`WDT_EVT_RESET] = 1'b1;
          end
        end
        wdt_pkg::WDT_SECOND: begin
          nxt_st.phase = wdt_pkg::WDT_SECOND;
        end
        wdt_pkg::WDT_PULSE: begin
          nxt_st.phase = wdt_pkg::WDT_PULSE;
        end
      endcase
    end

    // Reset pulse countdown, independent of later restarts
    if (st_ff.pulse_left != '0) begin
      nxt_st.pulse_left = st_ff.pulse_left - 1'b1; // see [R08]
    end
    if (st_ff.phase == wdt_pkg::WDT_PULSE && !restart && st_ff.pulse_left == '0 &&
        !expire) begin
      nxt_st.phase = wdt_pkg::WDT_SECOND;
    end
    nxt_st.sys.reset_n = !(nxt_st.pulse_left != '0); // see [R08]

    // Read data; read of status clears it, new events win
    nxt_st.rdata = '0;
    if (acc.rd) begin
      unique case (acc.addr)
        `WDT_OFS_CONTROL: begin
          nxt_st.rdata[`WDT_CTL_RUN_BIT] = st_ff.watchdog_run_enable;
          nxt_st.rdata[`WDT_CTL_PEND_BIT] = st_ff.timeout_irq_pending;
          nxt_st.rdata[`WDT_CTL_RST_EN_BIT] = st_ff.timeout_reset_enable;
          nxt_st.rdata[`WDT_CTL_IRQ_EN_BIT] = st_ff.timeout_irq_enable; // see [R14]
        end
        `WDT_OFS_LIMIT: nxt_st.rdata = st_ff.timeout_limit;
        `WDT_OFS_COUNT: nxt_st.rdata = st_ff.live_count; // see [R07]
        `WDT_OFS_PULSE_LEN: nxt_st.rdata[`WDT_PULSE_MSB:0] = st_ff.reset_pulse_cycles;
        `WDT_OFS_IRQ_STATUS: begin
          nxt_st.rdata[`WDT_EVT_WIDTH-1:0] = st_ff.evt_status;
          nxt_st.evt_status = '0;
        end
        `WDT_OFS_IRQ_MASK: nxt_st.rdata[`WDT_EVT_WIDTH-1:0] = st_ff.evt_mask;
        default: nxt_st.rdata = '0;
      endcase
    end
    nxt_st.evt_status = nxt_st.evt_status | evt;

    // Pending overrides clear in the same cycle
    if (expire && st_ff.phase == wdt_pkg::WDT_IDLE && st_ff.timeout_irq_enable) begin
      nxt_st.timeout_irq_pending = 1'b1; // see [R04]
    end

    // Interrupt to core and to the interrupt controller
    nxt_st.sys.irq_to_core = nxt_st.timeout_irq_pending; // see [R12]
    nxt_st.sys.irq_to_intc = nxt_st.timeout_irq_pending; // see [R12]
    nxt_st.irq = |(nxt_st.evt_status & nxt_st.evt_mask);
  end

  // ****************************************
  // Register stage
  // ****************************************
  // Async reset gives every register its reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0; // see [R10]
      st_ff.timeout_limit <= `WDT_LIMIT_RST;
      st_ff.live_count <= `WDT_LIMIT_RST;
      st_ff.reset_pulse_cycles <= `WDT_PULSE_RST;
      st_ff.phase <= wdt_pkg::WDT_IDLE;
      st_ff.sys.reset_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign prdata = st_ff.rdata;
  assign wdt_irq = st_ff.irq;
  assign irq_to_core = st_ff.sys.irq_to_core;
  assign irq_to_intc = st_ff.sys.irq_to_intc;
  assign wdt_reset_n = st_ff.sys.reset_n;
  assign timeout_seen_flag = st_ff.sys.timeout_seen;

endmodule

// ==== dv/wdt_top_monitor.sv ====
// Port-level assertion checker for the watchdog top
`timescale 1ns/1ns
module wdt_top_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // System side
  input wire logic wdt_irq,
  input wire logic irq_to_core,
  input wire logic irq_to_intc,
  input wire logic wdt_reset_n,
  input wire logic timeout_seen_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [8:0] low_ff;
  // Length of the running reset pulse; catches a stuck-low output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_ff <= 9'h000;
    end else begin
      low_ff <= wdt_reset_n ? 9'h000 : low_ff + 9'h001;
    end
  end
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  irq_pair_a: assert property (irq_to_core == irq_to_intc) else $error("irq copies differ");
  seen_sticky_a: assert property (timeout_seen_flag |=> timeout_seen_flag) else $error("flag lost");
  irq_cause_a: assert property (irq_to_core |-> timeout_seen_flag) else $error("irq without timeout");
  rst_cause_a: assert property ($fell(wdt_reset_n) |-> timeout_seen_flag) else $error("stray reset");
  pulse_max_a: assert property (low_ff <= 9'h0ff) else $error("reset pulse too long");
  status_cause_a: assert property (wdt_irq |-> timeout_seen_flag) else $error("status without timeout");
  cover property ($fell(wdt_reset_n));
  cover property ($rose(irq_to_core));
  cover property (pslverr);
endmodule

bind wdt_top wdt_top_monitor u_wdt_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_irq(wdt_irq),
  .irq_to_core(irq_to_core), .irq_to_intc(irq_to_intc), .wdt_reset_n(wdt_reset_n),
  .timeout_seen_flag(timeout_seen_flag));

// ==== dv/wdt_sys_model.sv ====
// Reset controller and interrupt controller stand-in
`timescale 1ns/1ns
module wdt_sys_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watchdog outputs
  input wire logic wdt_reset_n,
  input wire logic irq_to_intc,
  // Observations
  output logic [8:0] pulse_len,
  output logic [3:0] pulse_cnt,
  output logic irq_seen
);
  logic [8:0] run_ff;
  // Acts on the low level only, as a reset controller would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= 9'h000;
      pulse_len <= 9'h000;
      pulse_cnt <= 4'h0;
      irq_seen <= 1'b0;
    end else begin
      run_ff <= wdt_reset_n ? 9'h000 : run_ff + 9'h001;
      if (wdt_reset_n && run_ff != 9'h000) begin
        pulse_len <= run_ff;
        pulse_cnt <= pulse_cnt + 4'h1;
      end
      irq_seen <= irq_seen | irq_to_intc;
    end
  end
endmodule

// ==== dv/watchdog_timer_two_stage_tb.sv ====
// Register-level bench for the watchdog
`timescale 1ns/1ns
module watchdog_timer_two_stage_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_irq, irq_to_core, irq_to_intc;
  logic wdt_reset_n, timeout_seen_flag, last_err, irq_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] pulse_len;
  logic [3:0] pulse_cnt;
  int failures = 0;
  int cmp_count = 0;
  wdt_top u_wdt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_irq(wdt_irq),
    .irq_to_core(irq_to_core), .irq_to_intc(irq_to_intc), .wdt_reset_n(wdt_reset_n),
    .timeout_seen_flag(timeout_seen_flag));
  wdt_sys_model u_wdt_sys_model (.pclk(pclk), .presetn(presetn), .wdt_reset_n(wdt_reset_n),
    .irq_to_intc(irq_to_intc), .pulse_len(pulse_len), .pulse_cnt(pulse_cnt), .irq_seen(irq_seen));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // One APB transfer; waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(q, exp);
  endtask
  // Bounded wait for a level; a miss counts as a mismatch
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk1(s, v);
  endtask
  task automatic end_sim();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #30000;
    failures++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0000ffff);
    rd(8'h0c, 32'h0000ffff);
    rd(8'h10, 32'h000000ff);
    rd(8'h14, 32'h0);
    rd(8'h1c, 32'h0);
    chk1(last_err, 1'b1);
    apb(1'b1, 8'h00, 32'hffffffc8);
    rd(8'h00, 32'h0);
    // Limit and pulse set while stopped
    apb(1'b1, 8'h08, 32'h8);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h18, 32'h7);
    apb(1'b1, 8'h00, 32'h31);
    wait_lvl(irq_to_core, 1'b1);
    chk1(timeout_seen_flag, 1'b1);
    chk1(wdt_irq, 1'b1);
    wait_lvl(wdt_reset_n, 1'b0);
    wait_lvl(wdt_reset_n, 1'b1);
    @(posedge pclk);
    chk32({23'h0, pulse_len}, 32'h3);
    chk1(irq_seen, 1'b1);
    rd(8'h00, 32'h35);
    rd(8'h14, 32'h7);
    rd(8'h14, 32'h0);
    chk1(wdt_irq, 1'b0);
    apb(1'b1, 8'h00, 32'h31);
    rd(8'h00, 32'h35);
    apb(1'b1, 8'h00, 32'h35);
    rd(8'h00, 32'h31);
    apb(1'b1, 8'h04, 32'h1);
    wait_lvl(irq_to_core, 1'b1);
    apb(1'b1, 8'h00, 32'h04);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h8);
    // Run with both actions off: no irq_to_core, no further pulse
    apb(1'b1, 8'h00, 32'h01);
    repeat (40) @(posedge pclk);
    chk1(irq_to_core, 1'b0);
    chk32({28'h0, pulse_cnt}, 32'h1);
    rd(8'h00, 32'h01);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk1(timeout_seen_flag, 1'b0);
    chk1(wdt_irq, 1'b0);
    rd(8'h08, 32'h0000ffff);
    rd(8'h00, 32'h0);
    end_sim();
  end
endmodule
